// ==== verilog/mrs_pkg.sv ====
// Shared constants for the message receive block.
// Assumes a 32-bit classic Wishbone register bus, byte addressed.
package mrs_pkg;
  // Register byte offsets
  localparam logic [7:0] ADR_RESULT = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_RXSIZE = 8'h08;
  localparam logic [7:0] ADR_OFFSET = 8'h0c;
  localparam logic [7:0] ADR_LIMHI = 8'h10;
  localparam logic [7:0] ADR_CHTRK = 8'h14;
  localparam logic [7:0] ADR_RSVD0 = 8'h18;
  localparam logic [7:0] ADR_RSVD1 = 8'h1c;
  localparam logic [7:0] ADR_CTRL = 8'h20;
  localparam logic [7:0] ADR_SELECT = 8'h24;
  localparam logic [7:0] ADR_DEVTYP = 8'h28;
  localparam logic [7:0] ADR_MADDR = 8'h2c;
  localparam logic [7:0] ADR_MDATA = 8'h30;
  // Control bits
  localparam int CTRL_EXEC = 0;
  localparam int CTRL_ABORT = 1;
  localparam int CTRL_MODE = 2;
  // Upper result byte codes
  localparam logic [7:0] RES_BUSY = 8'h00;
  localparam logic [7:0] RES_DONE = 8'h10;
  localparam logic [7:0] ERR_ADDR = 8'h82;
  localparam logic [7:0] ERR_SIZE = 8'h83;
  localparam logic [7:0] ERR_CIRC = 8'h84;
  localparam logic [7:0] ERR_CHAN = 8'h85;
  localparam logic [7:0] ERR_CONN = 8'h86;
  localparam logic [7:0] ERR_XDEV = 8'h88;
  localparam logic [7:0] ERR_DSEL = 8'h89;
  localparam logic [7:0] ERR_NONE = 8'h00;
  // Status outcome field
  typedef enum logic [2:0] {
    link_failure, send_done, receive_done, abort_done,
    format_fault, sequence_fault, held_in_init, receive_fault
  } mrs_outcome_type;
  // Status command codes
  localparam logic [3:0] CMD_GENERIC_SEND = 4'h1;
  localparam logic [3:0] CMD_GENERIC_RECEIVE = 4'h2;
  localparam logic [3:0] CMD_ABORT = 4'h3;
  localparam logic [3:0] CMD_QUERY_SEND = 4'h8;
  localparam logic [3:0] CMD_QUERY_SERVE = 4'h9;
  localparam logic [3:0] CMD_REPLY_SEND = 4'hc;
  // Format fault detail codes
  localparam logic [7:0] FMT_NONE = 8'h00;
  localparam logic [7:0] FMT_CONN = 8'h01;
  localparam logic [7:0] FMT_MONTIME = 8'h02;
  localparam logic [7:0] FMT_RETRY = 8'h03;
  localparam logic [7:0] FMT_CYCLIC = 8'h04;
  localparam logic [7:0] FMT_CPU = 8'h05;
  localparam logic [7:0] FMT_ADDR = 8'h06;
  localparam logic [7:0] FMT_SIZE = 8'h07;
  localparam logic [7:0] FMT_FUNC = 8'h08;
  // Status field positions
  localparam int ST_REQ = 15;
  localparam int ST_RES_LO = 12;
  localparam int ST_CMD_LO = 8;
  // Accepted transmission device types
  localparam logic [7:0] DEV_TYPE_A = 8'h06;
  localparam logic [7:0] DEV_TYPE_B = 8'h10;
  localparam logic [15:0] RESULT_RST = 16'h0000;
endpackage

// ==== verilog/mrs_chk_if.sv ====
// Carries receive settings to the range checker and its verdict back.
// Assumes both ends run on the same clock; the path is combinational.
interface mrs_chk_if;
  logic [15:0] offset;
  logic [7:0] conn;
  logic [3:0] circ;
  logic [3:0] chan;
  logic [7:0] dev;
  logic [7:0] err;
  logic [7:0] fmt;
  modport ctl (output offset, conn, circ, chan, dev, input err, fmt);
  modport chk (input offset, conn, circ, chan, dev, output err, fmt);
endinterface

// ==== verilog/mrs_param_check.sv ====
// Range checker for the receive settings taken at the start of a request.
// Assumes settings are stable while the controller samples the verdict.
module mrs_param_check
  import mrs_pkg::*;
#(
  parameter int MEM_WORDS = 4096,
  parameter int CONN_MAX = 20,
  parameter int CIRC_MAX = 8,
  parameter int CHAN_MAX = 15
) (
  mrs_chk_if.chk c
);
  localparam logic [15:0] MEM_MAX = 16'(MEM_WORDS - 1);
  localparam logic [7:0] CONN_TOP = 8'(CONN_MAX);
  localparam logic [3:0] CIRC_TOP = 4'(CIRC_MAX);
  localparam logic [3:0] CHAN_TOP = 4'(CHAN_MAX);

  // First failing check wins, device type before numbers
  always_comb begin
    c.err = ERR_NONE;
    c.fmt = FMT_NONE;
    if (c.dev != DEV_TYPE_A && c.dev != DEV_TYPE_B) begin
      c.err = ERR_DSEL;
    end else if (c.circ == 4'h0 || c.circ > CIRC_TOP) begin
      c.err = ERR_CIRC;
    end else if (c.chan == 4'h0 || c.chan > CHAN_TOP) begin
      c.err = ERR_CHAN;
    end else if (c.conn == 8'h00 || c.conn > CONN_TOP) begin
      c.err = ERR_CONN;
      c.fmt = FMT_CONN;
    end else if (c.offset[15] || c.offset > MEM_MAX) begin
      // Top bit set is a negative offset and is never applied
      c.err = ERR_ADDR;
      c.fmt = FMT_ADDR;
    end
  end
endmodule // mrs_param_check

// ==== verilog/mrs_receiver.sv ====
// Message receive handler: stores a received stream into word memory.
// Assumes a classic Wishbone master and a same-clock receive stream.
//
// Overview of operation
// - Result upper byte: 00 busy, 10 done, 8y error
// - Result lower byte carries diagnostic data only
// - Bad store offset ends with code 82
// - Received size out of range gives 83
// - Bad circuit number gives code 84
// - Bad buffer channel gives code 85
// - Bad connection number gives code 86
// - Transmission device error gives code 88
// - Unavailable device type gives 89; 80,87 reserved
// - Request flag 1 pending, 0 once accepted
// - Outcome field encodes eight receive outcomes
// - Command field shows the operation in progress
// - Detail: fault code on format fault, else connection
// - Format fault detail codes 00 to 08
// - Size in words, or bytes in second mode
// - Data stored unconverted from offset, consecutive words
// - Negative store offsets are never applied
// - Writes past write_limit_high rejected, memory untouched
module mrs_receiver
  import mrs_pkg::*;
#(
  parameter int MEM_WORDS = 4096,
  parameter int AW = 12,
  parameter int MAX_WORDS = 2048
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic RX_VALID_I,
  input wire logic [15:0] RX_DATA_I,
  input wire logic RX_ERR_I,
  output logic RX_READY_O
);
  typedef enum logic [2:0] {S_IDLE, S_CHECK, S_HEAD, S_DATA} mrs_state_type;
  localparam logic [15:0] MEM_MAX = 16'(MEM_WORDS - 1);
  localparam logic [15:0] WORDS_TOP = 16'(MAX_WORDS);

  mrs_state_type state;
  mrs_state_type next_state;
  logic [15:0] result;
  logic req;
  mrs_outcome_type outcome;
  logic [7:0] fmt_code;
  logic [15:0] rx_size;
  logic [15:0] offset;
  logic [15:0] lim_hi;
  logic [15:0] chtrk;
  logic [15:0] rsvd0;
  logic [15:0] rsvd1;
  logic mode;
  logic [15:0] select;
  logic [7:0] devtyp;
  logic [AW-1:0] maddr;
  logic [15:0] mem [MEM_WORDS];
  logic [AW-1:0] wr_ptr;
  logic [15:0] left;
  logic [7:0] frames;
  logic [15:0] status;
  logic bus_req;
  logic wr_req;
  logic exec_pulse;
  logic abort_pulse;
  logic rx_take;
  logic mem_we;
  logic [15:0] words;
  logic [16:0] last_adr;
  logic [31:0] rd_mux;
  mrs_chk_if chk ();

  mrs_param_check #(.MEM_WORDS(MEM_WORDS)) u_chk (.c(chk));
  assign chk.offset = offset;
  assign chk.conn = select[7:0];
  assign chk.circ = select[11:8];
  assign chk.chan = select[15:12];
  assign chk.dev = devtyp;

  // Bus decode; a write takes effect on the edge that raises ack
  assign bus_req = CYC_I && STB_I && !ACK_O;
  assign wr_req = bus_req && WE_I;
  assign exec_pulse = wr_req && ADR_I == ADR_CTRL && SEL_I[0] && DAT_I[CTRL_EXEC];
  assign abort_pulse = wr_req && ADR_I == ADR_CTRL && SEL_I[0] && DAT_I[CTRL_ABORT];
  assign rx_take = RX_VALID_I && RX_READY_O;
  assign mem_we = state == S_DATA && rx_take && !RX_ERR_I;

  // Byte mode rounds a byte count up to whole words
  assign words = mode ? 16'((17'(rx_size) + 17'h1) >> 1) : rx_size;
  assign last_adr = 17'(offset) + 17'(words) - 17'h1;

  // Status word layout
  assign status = {req, outcome, CMD_GENERIC_RECEIVE,
                   (outcome == format_fault) ? fmt_code : select[7:0]};

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [3:0] sel,
                                        input logic [31:0] d);
    merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // Classic single-cycle ack, dropped the cycle after
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ACK_O <= 1'b0;
    end else begin
      ACK_O <= bus_req;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ADR_I)
      ADR_RESULT: rd_mux[15:0] = result;
      ADR_STATUS: rd_mux[15:0] = status;
      ADR_RXSIZE: rd_mux[15:0] = rx_size;
      ADR_OFFSET: rd_mux[15:0] = offset;
      ADR_LIMHI: rd_mux[15:0] = lim_hi;
      ADR_CHTRK: rd_mux[15:0] = chtrk;
      ADR_RSVD0: rd_mux[15:0] = rsvd0;
      ADR_RSVD1: rd_mux[15:0] = rsvd1;
      ADR_CTRL: rd_mux[CTRL_MODE] = mode;
      ADR_SELECT: rd_mux[15:0] = select;
      ADR_DEVTYP: rd_mux[7:0] = devtyp;
      ADR_MADDR: rd_mux[AW-1:0] = maddr;
      ADR_MDATA: rd_mux[15:0] = mem[maddr];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data registered with the ack
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      DAT_O <= 32'h0000_0000;
    end else if (bus_req && !WE_I) begin
      DAT_O <= rd_mux;
    end
  end

  // Software settings
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      offset <= 16'h0000;
      lim_hi <= 16'h0000;
      rsvd0 <= 16'h0000;
      rsvd1 <= 16'h0000;
      mode <= 1'b0;
      select <= 16'h0000;
      devtyp <= 8'h00;
      maddr <= '0;
    end else if (wr_req) begin
      case (ADR_I)
        ADR_OFFSET: offset <= merge(offset, SEL_I, DAT_I);
        ADR_LIMHI: lim_hi <= merge(lim_hi, SEL_I, DAT_I);
        ADR_RSVD0: rsvd0 <= merge(rsvd0, SEL_I, DAT_I);
        ADR_RSVD1: rsvd1 <= merge(rsvd1, SEL_I, DAT_I);
        ADR_CTRL: if (SEL_I[0]) mode <= DAT_I[CTRL_MODE];
        ADR_SELECT: select <= merge(select, SEL_I, DAT_I);
        ADR_DEVTYP: if (SEL_I[0]) devtyp <= DAT_I[7:0];
        ADR_MADDR: maddr <= AW'(merge(16'(maddr), SEL_I, DAT_I));
        default: ;
      endcase
    end
  end

  // Channel tracking: the block records the channel on each accepted request
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      chtrk <= 16'h0000;
    end else if (state == S_CHECK && chk.err == ERR_NONE) begin
      chtrk <= 16'(select[15:12]);
    end else if (wr_req && ADR_I == ADR_CHTRK) begin
      chtrk <= merge(chtrk, SEL_I, DAT_I);
    end
  end

  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: if (exec_pulse) next_state = S_CHECK;
      S_CHECK: next_state = (chk.err == ERR_NONE) ? S_HEAD : S_IDLE;
      S_HEAD: begin
        if (abort_pulse || (rx_take && RX_ERR_I)) begin
          next_state = S_IDLE;
        end else if (rx_take) begin
          next_state = S_DATA;
        end
      end
      S_DATA: begin
        if (abort_pulse || (rx_take && RX_ERR_I) || (mem_we && left == 16'h0001)) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
    // Header verdicts end the request before any memory write
    if (state == S_DATA && left == 16'h0000) begin
      next_state = S_IDLE;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Stream ready follows the next state, so it is a clean flop output
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RX_READY_O <= 1'b0;
    end else begin
      RX_READY_O <= (next_state == S_HEAD || next_state == S_DATA) && !(state == S_HEAD && rx_take);
    end
  end

  // Size header capture
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx_size <= 16'h0000;
    end else if (state == S_HEAD && rx_take && !RX_ERR_I) begin
      rx_size <= RX_DATA_I;
    end
  end

  // Store pointer and remaining count
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wr_ptr <= '0;
      left <= 16'h0000;
    end else if (state == S_CHECK) begin
      wr_ptr <= AW'(offset);
      left <= 16'hffff;
    end else if (state == S_DATA && left == 16'hffff) begin
      // One idle cycle after the header settles the range verdict
      left <= (words == 16'h0000 || words > WORDS_TOP || last_adr > 17'(lim_hi) ||
               last_adr > 17'(MEM_MAX)) ? 16'h0000 : words;
    end else if (mem_we && left != 16'hffff && left != 16'h0000) begin
      wr_ptr <= wr_ptr + 1'b1;
      left <= left - 16'h0001;
    end
  end

  // Memory writes, only inside a verified range
  always_ff @(posedge CLK_I) begin
    if (mem_we && left != 16'hffff && left != 16'h0000) begin
      mem[wr_ptr] <= RX_DATA_I;
    end
  end

  // Result, request flag and outcome
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      result <= RESULT_RST;
      req <= 1'b0;
      outcome <= held_in_init;
      fmt_code <= FMT_NONE;
      frames <= 8'h00;
    end else begin
      if (state == S_IDLE && exec_pulse) begin
        result <= {RES_BUSY, frames};
        req <= 1'b1;
      end else if (state == S_CHECK) begin
        req <= 1'b0;
        fmt_code <= chk.fmt;
        if (chk.err != ERR_NONE) begin
          result <= {chk.err, frames};
          outcome <= (chk.fmt != FMT_NONE) ? format_fault : link_failure;
        end
      end else if (state != S_IDLE && abort_pulse) begin
        result <= {RES_DONE, frames};
        outcome <= abort_done;
      end else if (state != S_IDLE && rx_take && RX_ERR_I) begin
        result <= {ERR_XDEV, frames};
        outcome <= receive_fault;
      end else if (state == S_DATA && left == 16'h0000) begin
        if (words == 16'h0000 || words > WORDS_TOP) begin
          result <= {ERR_SIZE, frames};
        end else begin
          result <= {ERR_ADDR, frames};
        end
        outcome <= format_fault;
        fmt_code <= (words == 16'h0000 || words > WORDS_TOP) ? FMT_SIZE : FMT_ADDR;
      end else if (mem_we && left == 16'h0001) begin
        result <= {RES_DONE, 8'(frames + 8'h01)};
        outcome <= receive_done;
        frames <= frames + 8'h01;
      end
    end
  end

  // Checks
  sequence s_exec;
    state == S_IDLE && exec_pulse;
  endsequence
  property p_busy;
    @(posedge CLK_I) disable iff (!NRST_I) s_exec |=> result[15:8] == RES_BUSY;
  endproperty
  a_busy: assert property (p_busy) else $error("busy code missing");
  property p_req;
    @(posedge CLK_I) disable iff (!NRST_I) s_exec |=> req ##1 !req;
  endproperty
  a_req: assert property (p_req) else $error("request flag sequence wrong");
  property p_last;
    @(posedge CLK_I) disable iff (!NRST_I)
      mem_we && left == 16'h0001 |=> result[15:8] == RES_DONE && outcome == receive_done;
  endproperty
  a_last: assert property (p_last) else $error("complete not after last word");
  property p_neg;
    @(posedge CLK_I) disable iff (!NRST_I)
      state == S_CHECK && offset[15] && devtyp == DEV_TYPE_A && chk.err == ERR_ADDR |=>
      result[15:8] == ERR_ADDR && state == S_IDLE;
  endproperty
  a_neg: assert property (p_neg) else $error("negative offset accepted");
  property p_guard;
    @(posedge CLK_I) disable iff (!NRST_I)
      mem_we && left != 16'hffff && left != 16'h0000 |->
      17'(wr_ptr) <= 17'(lim_hi) && 16'(wr_ptr) >= offset;
  endproperty
  a_guard: assert property (p_guard) else $error("write outside range");
  property p_step;
    @(posedge CLK_I) disable iff (!NRST_I)
      mem_we && left > 16'h0001 && left != 16'hffff |=> wr_ptr == $past(wr_ptr) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("store address not ascending");
  property p_detail;
    @(posedge CLK_I) disable iff (!NRST_I)
      outcome != format_fault |-> status[7:0] == select[7:0] && status[11:8] == CMD_GENERIC_RECEIVE;
  endproperty
  a_detail: assert property (p_detail) else $error("detail field wrong");
  property p_xdev;
    @(posedge CLK_I) disable iff (!NRST_I)
      state == S_DATA && rx_take && RX_ERR_I && !abort_pulse |=>
      result[15:8] == ERR_XDEV && outcome == receive_fault && !RX_READY_O;
  endproperty
  a_xdev: assert property (p_xdev) else $error("device error not reported");
endmodule // mrs_receiver

// ==== testbench/mrs_sender.sv ====
// Remote sending station model: pushes a size header, then data words.
// Assumes the same clock as the receiver and a valid/ready word stream.
module mrs_sender (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [15:0] data_o,
  output logic err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] words[$];
  int err_at = -1;
  bit slow = 0;

  // Idle line at time zero
  initial begin
    valid_o = 1'b0;
    data_o = 16'h0000;
    err_o = 1'b0;
  end

  // One word held until taken; released line shows inverted data
  task automatic put(input logic [15:0] d, input logic e, input logic last);
    valid_o <= 1'b1;
    data_o <= d;
    err_o <= e;
    do @(posedge clk_i); while (ready_i !== 1'b1);
    if (last || slow) begin
      valid_o <= 1'b0;
      data_o <= ~d; // Stale value never looks valid
      err_o <= 1'b0;
    end
    if (slow) repeat (2) @(posedge clk_i);
  endtask

  // Header first, then exactly n words
  task automatic run(input logic [15:0] hdr, input int n);
    put(hdr, 1'b0, n == 0);
    for (int i = 0; i < n; i++) put(words[i], i == err_at, i == n - 1);
  endtask
endmodule // mrs_sender

// ==== testbench/tb_top.sv ====
// Self-checking bench for the message receive block.
// Assumes a small word memory so range limits are cheap to reach.
module tb_top
  import mrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, last_q, m, v;
  logic [31:0] dat_o;
  logic ack, rx_v, rx_e, rx_rdy;
  logic [15:0] rx_d, lf = 16'h0037, first_w;
  logic [31:0] note_mask[$], note_val[$];
  int fails = 0, n_tests = 0;

  always #25 clk = ~clk;

  mrs_receiver #(.MEM_WORDS(64), .AW(6)) mrs_receiver_i (.CLK_I(clk), .NRST_I(nrst), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .RX_VALID_I(rx_v),
    .RX_DATA_I(rx_d), .RX_ERR_I(rx_e), .RX_READY_O(rx_rdy));
  mrs_sender mrs_sender_i (.clk_i(clk), .ready_i(rx_rdy), .valid_o(rx_v), .data_o(rx_d), .err_o(rx_e));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] st(input mrs_outcome_type o, input logic [7:0] d);
    return {16'h0, 1'b0, o, CMD_GENERIC_RECEIVE, d};
  endfunction

  task test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Classic single cycle; waits for ack, bench timeout ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'h3;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, {16'h0, d});
  endtask

  // Every read leaves a note; a zero mask means no comparison
  task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] ev);
    note_mask.push_back(mk);
    note_val.push_back(ev);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic poll;
    int k = 0;
    do begin
      rd(ADR_RESULT, 32'h0, 32'h0);
      k++;
    end while (last_q[15:8] === RES_BUSY && k < 100);
    // A request that never leaves busy is a failure, not a silent pass
    if (last_q[15:8] === RES_BUSY) begin
      fails++;
      test_done();
    end
  endtask

  task automatic go(input logic [15:0] s, input logic [7:0] dv, input logic [15:0] off, input logic md);
    wr(ADR_SELECT, s);
    wr(ADR_DEVTYP, dv);
    wr(ADR_OFFSET, off);
    wr(ADR_CTRL, {13'h0, md, 2'b01});
  endtask

  // Full receive: settings, exec, stream, then result, status and, when done, memory
  task automatic rx(input logic [15:0] off, hdr, input int n, input logic md, input int ea,
                    input logic [7:0] res, input logic [31:0] stv);
    mrs_sender_i.words.delete();
    for (int i = 0; i < n; i++) begin
      lf = lfsr(lf);
      mrs_sender_i.words.push_back(lf);
    end
    mrs_sender_i.err_at = ea;
    mrs_sender_i.slow = md;
    go(16'h1105, md ? DEV_TYPE_B : DEV_TYPE_A, off, md);
    mrs_sender_i.run(hdr, n);
    poll();
    rd(ADR_RESULT, 32'hff00, {16'h0, res, 8'h0});
    rd(ADR_STATUS, 32'hffff, stv);
    if (res == RES_DONE) begin
      first_w = mrs_sender_i.words[0];
      rd(ADR_RXSIZE, 32'hffff, {16'h0, hdr});
      for (int i = 0; i < n; i++) begin
        wr(ADR_MADDR, off + 16'(i));
        rd(ADR_MDATA, 32'hffff, {16'h0, mrs_sender_i.words[i]});
      end
    end
  endtask

  // Compares the oldest note against each read answer
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      last_q = dat_o;
      m = note_mask.pop_front();
      v = note_val.pop_front();
      if (m != 32'h0) begin
        n_tests++;
        if ((dat_o & m) !== (v & m)) begin
          fails++;
          $display("BAD t=%0t got %h exp %h", $time, dat_o & m, v & m);
        end
      end
    end
  end

  // Hang guard, far beyond the expected run
  initial begin
    #(50 * 20000);
    fails++;
    test_done();
  end

  // Setting faults: select, device, offset, result byte, status
  logic [15:0] t_sel[6] = '{16'h1105, 16'h1005, 16'h0105, 16'h1100, 16'h1115, 16'h1105};
  logic [7:0] t_dev[6] = '{8'h07, 8'h06, 8'h06, 8'h06, 8'h06, 8'h06};
  logic [15:0] t_off[6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h8000};
  logic [7:0] t_res[6] = '{ERR_DSEL, ERR_CIRC, ERR_CHAN, ERR_CONN, ERR_CONN, ERR_ADDR};

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(ADR_RESULT, 32'hffff, {16'h0, RESULT_RST});
    rd(ADR_STATUS, 32'hffff, st(held_in_init, 8'h00));
    rd(8'h3c, 32'hffffffff, 32'h0);
    // Reserved pair is never written by the bench, so it keeps its reset value
    rd(ADR_RSVD0, 32'hffff, 32'h0);
    rd(ADR_RSVD1, 32'hffff, 32'h0);
    wr(ADR_CHTRK, 16'h0000);
    wr(ADR_LIMHI, 16'h0028);
    rd(ADR_LIMHI, 32'hffff, 32'h28);
    rx(16'h0008, 16'h0005, 3, 1'b1, -1, RES_DONE, st(receive_done, 8'h05));
    // Boundary fit: words 37..40 end exactly at the limit; last run that completes
    rx(16'h0025, 16'h0004, 4, 1'b0, -1, RES_DONE, st(receive_done, 8'h05));
    rd(ADR_CHTRK, 32'hffff, 32'h1);
    rx(16'h0025, 16'h0000, 0, 1'b0, -1, ERR_SIZE, st(format_fault, FMT_SIZE));
    // One word is taken past the limit and must not land in memory
    rx(16'h0025, 16'h0005, 1, 1'b0, -1, ERR_ADDR, st(format_fault, FMT_ADDR));
    wr(ADR_MADDR, 16'h0025);
    rd(ADR_MDATA, 32'hffff, {16'h0, first_w});
    rx(16'h0008, 16'h0002, 2, 1'b0, 1, ERR_XDEV, st(receive_fault, 8'h05));
    for (int i = 0; i < 6; i++) begin
      go(t_sel[i], t_dev[i], t_off[i], 1'b0);
      poll();
      rd(ADR_RESULT, 32'hff00, {16'h0, t_res[i], 8'h0});
      rd(ADR_STATUS, 32'hffff, (i < 3) ? st(link_failure, 8'h05) :
         st(format_fault, (i == 5) ? FMT_ADDR : FMT_CONN));
    end
    // Abort while waiting for a header
    go(16'h1105, DEV_TYPE_A, 16'h0008, 1'b0);
    rd(ADR_RESULT, 32'hff00, {16'h0, RES_BUSY, 8'h0});
    rd(ADR_STATUS, 32'h8000, 32'h0);
    wr(ADR_CTRL, 16'h0002);
    poll();
    rd(ADR_RESULT, 32'hff00, {16'h0, RES_DONE, 8'h0});
    rd(ADR_STATUS, 32'hffff, st(abort_done, 8'h05));
    test_done();
  end
endmodule // tb_top
